//--- rtl/tol_stage.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tol_stage
  import tol_pkg::*;
#(
  parameter longint STEP_CYCLES = TOL_STEP_CYC  // clocks per 5 ms delay step
) (
  input wire logic clock_in,                  // 200 mhz clock
  input wire logic srst_in,                   // synchronous reset, active high
  input wire logic cycle_tick_in,             // program cycle start pulse
  input wire logic block_in,                  // blocking matrix input
  input wire logic [TOL_CAP_W-1:0] cap_in,    // thermal capacity, 0.1 %
  input wire logic [TOL_CAP_W-1:0] current_in, // measured current, 0.1 % of nominal
  input wire logic [7:0] addr_in,             // register byte address
  input wire logic [31:0] wdata_in,           // write data
  input wire logic wr_in,                     // write strobe
  input wire logic rd_in,                     // read strobe
  output logic [31:0] rdata_out,              // read data, cycle after strobe
  output tol_outs_t outs_out,                 // alarm1/alarm2/inhibit/trip
  output logic start_out,                     // start indication
  output logic blocked_out,                   // blocked indication
  output tol_cond_t cond_out,                 // operating condition code
  output tol_load_t load_out,                 // load classification
  output tol_fault_t fault_out,               // setting-fault flags
  output logic [TOL_FAC_W-1:0] sf_used_out,   // service factor in use
  output logic [TOL_FAC_W-1:0] amb_k_used_out, // ambient correction in use
  output logic [TOL_FAC_W-1:0] nom_used_out   // nominal scale in use
);

  localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);
  // the delay timebase divides the clock into 5 ms steps
  // a step of one clock is allowed: STEP_LAST is then zero
  // and every clock counts as a whole step
  // the step counter is 32 bits wide so long steps fit
  // simulation shortens the step through the parameter;
  // the delay setting itself keeps its full range

  // settings registers
  logic [3:0] en_r;                           // output enables
  logic [TOL_LVL_W-1:0] lvl_a1_r;             // alarm 1 level
  logic [TOL_LVL_W-1:0] lvl_a2_r;             // alarm 2 level
  logic [TOL_LVL_W-1:0] lvl_inh_r;            // restart inhibit level
  logic [TOL_LVL_W-1:0] lvl_trip_r;           // trip level
  logic [TOL_DLY_W-1:0] trip_dly_r;           // added trip delay, steps
  logic [TOL_FAC_W-1:0] sf_r;                 // service factor setting
  logic [TOL_FAC_W-1:0] kmin_r;               // ambient k at min temp
  logic [TOL_FAC_W-1:0] kmax_r;               // ambient k at max temp
  logic [TOL_FAC_W-1:0] nom_r;                // nominal current scale
  // timing state
  logic [31:0] step_cnt_r;                    // clocks within a delay step
  logic [TOL_DLY_W-1:0] dly_cnt_r;            // elapsed delay steps
  logic dly_done;                             // added delay has passed
  // comparisons and validity
  logic reach_a1, reach_a2, reach_inh, reach_trip;
  logic sf_bad, amb_bad, nom_bad, k_incons;
  logic [TOL_FAC_W-1:0] sf_eff;               // service factor after override
  logic [TOL_CAP_W+TOL_FAC_W-1:0] pickup_lim; // pick-up current limit, 0.1 %
  tol_load_t load_nxt;
  tol_outs_t outs_nxt;
  tol_cond_t cond_nxt;

  // all settings sit in one bank; a group switch is software
  // rewriting these words, and each new value acts from the
  // clock after its write, so a half-applied group is seen
  // by the comparators for no longer than the writes take
  // status and unmapped words ignore writes silently
  // levels and delay are clipped rather than refused, so a
  // careless write still leaves a usable setting
  // the output enables come straight from the low bits
  // register writes; new settings act from the next clock
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      en_r <= 4'h0;
      lvl_a1_r <= TOL_RST_ALARM1_LVL;
      lvl_a2_r <= TOL_RST_ALARM2_LVL;
      lvl_inh_r <= TOL_RST_INHIBIT_LVL;
      lvl_trip_r <= TOL_RST_TRIP_LVL;
      trip_dly_r <= TOL_RST_TRIP_DELAY;
      sf_r <= TOL_FAC_ONE;
      kmin_r <= TOL_FAC_ONE;
      kmax_r <= TOL_FAC_ONE;
      nom_r <= TOL_FAC_ONE;
    end else if (wr_in) begin
      unique case (addr_in)
        TOL_ADDR_CTRL: en_r <= wdata_in[3:0];
        TOL_ADDR_ALARM1_LVL: lvl_a1_r <= clip_lvl(wdata_in);
        TOL_ADDR_ALARM2_LVL: lvl_a2_r <= clip_lvl(wdata_in);
        TOL_ADDR_INHIBIT_LVL: lvl_inh_r <= clip_lvl(wdata_in);
        TOL_ADDR_TRIP_LVL: lvl_trip_r <= clip_lvl(wdata_in);
        TOL_ADDR_TRIP_DELAY: begin
          // delay range is clipped at 3600 s
          if (wdata_in[31:TOL_DLY_W] != '0 || wdata_in[TOL_DLY_W-1:0] > TOL_DLY_MAX) begin
            trip_dly_r <= TOL_DLY_MAX;
          end else begin
            trip_dly_r <= wdata_in[TOL_DLY_W-1:0];
          end
        end
        TOL_ADDR_SERVICE_FACTOR: sf_r <= wdata_in[TOL_FAC_W-1:0];
        TOL_ADDR_AMB_K_MIN: kmin_r <= wdata_in[TOL_FAC_W-1:0];
        TOL_ADDR_AMB_K_MAX: kmax_r <= wdata_in[TOL_FAC_W-1:0];
        TOL_ADDR_NOM_SCALE: nom_r <= wdata_in[TOL_FAC_W-1:0];
        default: ;  // unmapped or read-only: ignored
      endcase
    end
  end

  // any bit above the level field counts as out of range;
  // clipping to the top of the range keeps an overshoot
  // from wrapping to a tiny, over-sensitive level
  // level setting limited to 150 %
  function automatic logic [TOL_LVL_W-1:0] clip_lvl(input logic [31:0] v);
    if (v[31:TOL_LVL_W] != '0 || v[TOL_LVL_W-1:0] > TOL_LVL_MAX) begin
      return TOL_LVL_MAX;
    end
    return v[TOL_LVL_W-1:0];
  endfunction

  // capacity is unsigned, so a zero level is always reached;
  // that is the user's choice and is not guarded against
  // the comparators are combinational on purpose: the result
  // is only latched at a cycle start, so a capacity glitch
  // between cycle starts never reaches an output
  // the levels are zero-extended to the capacity width
  // threshold comparisons, equal counts as reached
  always_comb begin
    reach_a1 = cap_in >= TOL_CAP_W'(lvl_a1_r);
    reach_a2 = cap_in >= TOL_CAP_W'(lvl_a2_r);
    reach_inh = cap_in >= TOL_CAP_W'(lvl_inh_r);
    reach_trip = cap_in >= TOL_CAP_W'(lvl_trip_r);
  end

  // a zero factor or one above 5.00 is treated as a bad
  // setting; the flag and the substitution come from the
  // same term so they can never disagree
  // inconsistent ambient k is only judged when both ends are
  // valid, so one fault does not light two flags
  // pick-up limit is factor x nominal, in current units
  // setting validity checks and overrides to 1.0
  always_comb begin
    sf_bad = (sf_r == '0) || (sf_r > TOL_FAC_MAX);
    amb_bad = (kmin_r == '0) || (kmin_r > TOL_FAC_MAX) ||
              (kmax_r == '0) || (kmax_r > TOL_FAC_MAX);
    nom_bad = (nom_r == '0) || (nom_r > TOL_FAC_MAX);
    k_incons = !amb_bad && (kmin_r < kmax_r);
    sf_eff = sf_bad ? TOL_FAC_ONE : sf_r;
    pickup_lim = (TOL_CAP_W+TOL_FAC_W)'(sf_eff) * (TOL_CAP_W+TOL_FAC_W)'(10);
  end

  // checks run light, high overload, overloading, then normal; the light-load test
  // comes first so a zero current never reads as normal
  // overloading needs more than the pick-up limit, so a
  // current exactly at the limit stays normal
  // a service factor above 2.00 leaves no overloading band:
  // such currents read as high overload directly
  // load classification from measured current
  always_comb begin
    if (current_in < TOL_LIGHT_LIMIT) begin
      load_nxt = TOL_LOAD_LIGHT;
    end else if (current_in > TOL_HIGH_LIMIT) begin
      load_nxt = TOL_LOAD_HIGH;
    end else if ((TOL_CAP_W+TOL_FAC_W)'(current_in) > pickup_lim) begin
      load_nxt = TOL_LOAD_OVER;
    end else begin
      load_nxt = TOL_LOAD_NORMAL;
    end
  end

  // the step counter only runs while the stage is started;
  // releasing the start clears it so the next start always
  // begins a fresh step rather than a partial one
  // hazard: the delay is measured from the start rising, not
  // from the level being reached, and the output register
  // below rounds it up to the next cycle start
  // a user must allow two program cycles of extra latency
  // on top of the set delay when grading protection
  // delay step timebase, runs only while started
  always_ff @(posedge clock_in) begin
    if (srst_in || !start_out) begin
      step_cnt_r <= 32'h0;
    end else if (step_cnt_r >= STEP_LAST) begin
      step_cnt_r <= 32'h0;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end

  // elapsed delay steps; cleared on release or blocking
  always_ff @(posedge clock_in) begin
    if (srst_in || !start_out) begin
      dly_cnt_r <= '0;
    end else if (step_cnt_r >= STEP_LAST && !dly_done) begin
      dly_cnt_r <= dly_cnt_r + TOL_DLY_W'(1);
    end
  end

  // zero delay passes straight through
  assign dly_done = dly_cnt_r >= trip_dly_r;

  // pick-up means the trip level reached with trip enabled
  // blocking at a cycle start turns a pick-up into a blocked
  // indication and drops a running start; dropping the start
  // also clears the delay count, the same release path as a
  // pick-up that goes away
  // a source that raises blocking less than one cycle before
  // the delay runs out may be too late to stop the trip
  // blocking between cycle starts is not seen at all
  // start and blocked indications, evaluated per program cycle
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      start_out <= 1'b0;
      blocked_out <= 1'b0;
    end else if (cycle_tick_in) begin
      // blocking only counts when it is present at a cycle start
      start_out <= en_r[TOL_CTRL_EN_TRIP] && reach_trip && !block_in;
      blocked_out <= en_r[TOL_CTRL_EN_TRIP] && reach_trip && block_in;
    end
  end

  // a disabled output stays low whatever the capacity
  // blocking holds every output low, not only the trip
  // the trip needs the registered start, so it lags the start
  // by one cycle even with no added delay
  // the trip also needs the level still reached, so a drop
  // below the level in the same cycle suppresses it
  // enabled and unblocked output levels
  always_comb begin
    outs_nxt.alarm1 = en_r[TOL_CTRL_EN_ALARM1] && reach_a1 && !block_in;
    outs_nxt.alarm2 = en_r[TOL_CTRL_EN_ALARM2] && reach_a2 && !block_in;
    outs_nxt.inhibit = en_r[TOL_CTRL_EN_INHIBIT] && reach_inh && !block_in;
    // trip only after the started stage has served its delay
    outs_nxt.trip = start_out && reach_trip && !block_in && dly_done;
  end

  // only one code is reported; blocking outranks a trip,
  // which outranks the inhibit and the two alarms
  // normal is shown exactly when no output is driven and no blocked pick-up is present
  // the code uses the same next values as the outputs,
  // so both always change at the same cycle start
  // condition code, most severe first
  always_comb begin
    if (en_r[TOL_CTRL_EN_TRIP] && reach_trip && block_in) begin
      cond_nxt = TOL_COND_BLOCKED;
    end else if (outs_nxt.trip) begin
      cond_nxt = TOL_COND_TRIP;
    end else if (outs_nxt.inhibit) begin
      cond_nxt = TOL_COND_INHIBIT;
    end else if (outs_nxt.alarm2) begin
      cond_nxt = TOL_COND_ALARM2;
    end else if (outs_nxt.alarm1) begin
      cond_nxt = TOL_COND_ALARM1;
    end else begin
      cond_nxt = TOL_COND_NORMAL;
    end
  end

  // the alarm, inhibit and trip outputs and the code come from flip-flops and only move at a
  // cycle start, so downstream logic sees one value per cycle
  // load class follows the same pacing as the outputs
  // reset leaves all outputs low and the code at normal
  // so nothing is driven before the first cycle start
  // outputs and condition code update at each program cycle start
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      outs_out <= '0;
      cond_out <= TOL_COND_NORMAL;
      load_out <= TOL_LOAD_LIGHT;
    end else if (cycle_tick_in) begin
      outs_out <= outs_nxt;
      cond_out <= cond_nxt;
      load_out <= load_nxt;
    end
  end

  // flags have no latch or clear: each is shown only while
  // its setting is bad and drops the clock after a good write
  // the substituted value is what the thermal image would use
  // these are not paced by the cycle start, since settings
  // change from software and not from the measurement
  // fault flags and substituted values follow settings every clock
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      fault_out <= '0;
      sf_used_out <= TOL_FAC_ONE;
      amb_k_used_out <= TOL_FAC_ONE;
      nom_used_out <= TOL_FAC_ONE;
    end else begin
      fault_out.service_factor <= sf_bad;
      fault_out.ambient <= amb_bad;
      fault_out.nominal <= nom_bad;
      fault_out.amb_k_inconsistent <= k_incons;
      sf_used_out <= sf_eff;
      amb_k_used_out <= amb_bad ? TOL_FAC_ONE : kmax_r;
      nom_used_out <= nom_bad ? TOL_FAC_ONE : nom_r;
    end
  end

  // the read port answers one clock after the strobe and
  // returns zero otherwise, so a stale word is never seen
  // status fields mirror the output registers bit for bit
  // settings read back as stored, after any clipping, so
  // software can see what is really in force
  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clock_in) begin
    if (srst_in || !rd_in) begin
      rdata_out <= 32'h0;
    end else begin
      unique case (addr_in)
        TOL_ADDR_CTRL: rdata_out <= {28'h0, en_r};
        TOL_ADDR_ALARM1_LVL: rdata_out <= 32'(lvl_a1_r);
        TOL_ADDR_ALARM2_LVL: rdata_out <= 32'(lvl_a2_r);
        TOL_ADDR_INHIBIT_LVL: rdata_out <= 32'(lvl_inh_r);
        TOL_ADDR_TRIP_LVL: rdata_out <= 32'(lvl_trip_r);
        TOL_ADDR_TRIP_DELAY: rdata_out <= 32'(trip_dly_r);
        TOL_ADDR_STATUS: rdata_out <= {12'h0, fault_out, 2'h0, load_out, 1'b0, cond_out,
                                       2'h0, blocked_out, start_out, outs_out};
        TOL_ADDR_SERVICE_FACTOR: rdata_out <= 32'(sf_r);
        TOL_ADDR_AMB_K_MIN: rdata_out <= 32'(kmin_r);
        TOL_ADDR_AMB_K_MAX: rdata_out <= 32'(kmax_r);
        TOL_ADDR_NOM_SCALE: rdata_out <= 32'(nom_r);
        default: rdata_out <= 32'h0;  // unmapped reads as zero
      endcase
    end
  end

endmodule
`default_nettype wire

//--- rtl/tol_pkg.sv
package tol_pkg;
  // register byte addresses, one 32-bit word each
  localparam logic [7:0] TOL_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TOL_ADDR_ALARM1_LVL = 8'h04;
  localparam logic [7:0] TOL_ADDR_ALARM2_LVL = 8'h08;
  localparam logic [7:0] TOL_ADDR_INHIBIT_LVL = 8'h0c;
  localparam logic [7:0] TOL_ADDR_TRIP_LVL = 8'h10;
  localparam logic [7:0] TOL_ADDR_TRIP_DELAY = 8'h14;
  localparam logic [7:0] TOL_ADDR_STATUS = 8'h18;
  localparam logic [7:0] TOL_ADDR_SERVICE_FACTOR = 8'h1c;
  localparam logic [7:0] TOL_ADDR_AMB_K_MIN = 8'h20;
  localparam logic [7:0] TOL_ADDR_AMB_K_MAX = 8'h24;
  localparam logic [7:0] TOL_ADDR_NOM_SCALE = 8'h28;
  // control field positions
  localparam int TOL_CTRL_EN_ALARM1 = 0;
  localparam int TOL_CTRL_EN_ALARM2 = 1;
  localparam int TOL_CTRL_EN_INHIBIT = 2;
  localparam int TOL_CTRL_EN_TRIP = 3;
  // status field positions
  localparam int TOL_ST_OUTS_LSB = 0;
  localparam int TOL_ST_START = 4;
  localparam int TOL_ST_BLOCKED = 5;
  localparam int TOL_ST_COND_LSB = 8;
  localparam int TOL_ST_LOAD_LSB = 12;
  localparam int TOL_ST_FAULT_LSB = 16;
  // widths: thermal capacity and current in 0.1 % units
  localparam int TOL_LVL_W = 11;
  localparam int TOL_CAP_W = 16;
  localparam int TOL_DLY_W = 20;
  localparam int TOL_FAC_W = 10;
  // reset values and setting limits
  localparam logic [TOL_LVL_W-1:0] TOL_RST_ALARM1_LVL = 11'h190;  // 40.0 %
  localparam logic [TOL_LVL_W-1:0] TOL_RST_ALARM2_LVL = 11'h190;  // 40.0 %
  localparam logic [TOL_LVL_W-1:0] TOL_RST_INHIBIT_LVL = 11'h320; // 80.0 %
  localparam logic [TOL_LVL_W-1:0] TOL_RST_TRIP_LVL = 11'h3e8;    // 100.0 %
  localparam logic [TOL_LVL_W-1:0] TOL_LVL_MAX = 11'h5dc;         // 150.0 %
  localparam logic [TOL_DLY_W-1:0] TOL_RST_TRIP_DELAY = 20'h00000; // no added delay
  localparam logic [TOL_DLY_W-1:0] TOL_DLY_MAX = 20'hafc80;        // 3600 s in 5 ms steps
  localparam logic [TOL_FAC_W-1:0] TOL_FAC_ONE = 10'h064;          // 1.00 in 0.01 steps
  localparam logic [TOL_FAC_W-1:0] TOL_FAC_MAX = 10'h1f4;          // 5.00
  // load classification limits in 0.1 % of nominal
  localparam logic [TOL_CAP_W-1:0] TOL_LIGHT_LIMIT = 16'h000a;     // 1 %
  localparam logic [TOL_CAP_W-1:0] TOL_HIGH_LIMIT = 16'h07d0;      // 2 x nominal
  // timing
  localparam longint TOL_CLK_HZ = 200000000;
  localparam longint TOL_STEP_US = 5000;                           // 5 ms delay step
  localparam longint TOL_STEP_CYC = TOL_STEP_US * TOL_CLK_HZ / 1000000;

  // operating condition code
  typedef enum logic [2:0] {
    TOL_COND_NORMAL,
    TOL_COND_ALARM1,
    TOL_COND_ALARM2,
    TOL_COND_INHIBIT,
    TOL_COND_TRIP,
    TOL_COND_BLOCKED
  } tol_cond_t;

  // load classification
  typedef enum logic [1:0] {
    TOL_LOAD_LIGHT,
    TOL_LOAD_NORMAL,
    TOL_LOAD_OVER,
    TOL_LOAD_HIGH
  } tol_load_t;

  // stage outputs toward i/o matrix and user logic
  typedef struct packed {
    logic trip;
    logic inhibit;
    logic alarm2;
    logic alarm1;
  } tol_outs_t;

  // setting-fault flags
  typedef struct packed {
    logic amb_k_inconsistent;
    logic nominal;
    logic ambient;
    logic service_factor;
  } tol_fault_t;
endpackage

//--- verification/tol_stage_chk.sv
`timescale 1ns/100ps
`default_nettype none
// watches the stage ports for blocking, hold and override relations
module tol_stage_chk
  import tol_pkg::*;
(
  input wire logic clock_in, // clock
  input wire logic srst_in, // sync reset
  input wire logic cycle_tick_in, // cycle start
  input wire logic block_in, // blocking
  input wire logic [TOL_CAP_W-1:0] current_in, // current
  input wire tol_outs_t outs_out, // outputs
  input wire logic start_out, // start
  input wire tol_cond_t cond_out, // condition
  input wire tol_load_t load_out, // load class
  input wire tol_fault_t fault_out, // faults
  input wire logic [TOL_FAC_W-1:0] sf_used_out, // factor used
  input wire logic [TOL_FAC_W-1:0] amb_k_used_out, // ambient k used
  input wire logic [TOL_FAC_W-1:0] nom_used_out // nominal used
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // a cycle start that sees blocking
  sequence s_blk_tick;
    cycle_tick_in && block_in;
  endsequence
  // trip rising edge
  sequence s_trip_rise;
    $rose(outs_out.trip);
  endsequence
  AST_BLOCK_QUIET: assert property (s_blk_tick |=> outs_out == 4'h0) else $error("outputs while blocked");
  AST_BLOCK_NOSTART: assert property (s_blk_tick |=> !start_out) else $error("start while blocked");
  AST_OUTS_HOLD: assert property (!cycle_tick_in |=> $stable(outs_out)) else $error("outputs moved off tick");
  AST_NORMAL_QUIET: assert property (cond_out == TOL_COND_NORMAL |-> outs_out == 4'h0) else $error("normal drives");
  AST_TRIP_AFTER_START: assert property (s_trip_rise |-> $past(start_out)) else $error("trip without start");
  AST_SF_OVERRIDE: assert property (fault_out.service_factor |-> sf_used_out == TOL_FAC_ONE)
    else $error("factor not overridden");
  AST_AMB_OVERRIDE: assert property (fault_out.ambient |-> amb_k_used_out == TOL_FAC_ONE)
    else $error("ambient not overridden");
  AST_NOM_OVERRIDE: assert property (fault_out.nominal |-> nom_used_out == TOL_FAC_ONE)
    else $error("nominal not overridden");
  AST_LIGHT_LOAD: assert property (
    cycle_tick_in && current_in < TOL_LIGHT_LIMIT |=> load_out == TOL_LOAD_LIGHT) else $error("light load missed");
  AST_HIGH_LOAD: assert property (
    cycle_tick_in && current_in > TOL_HIGH_LIMIT |=> load_out == TOL_LOAD_HIGH) else $error("high overload missed");
endmodule
bind tol_stage tol_stage_chk tol_stage_chk_inst (.clock_in(clock_in), .srst_in(srst_in), .cycle_tick_in(cycle_tick_in),
  .block_in(block_in), .current_in(current_in), .outs_out(outs_out), .start_out(start_out), .cond_out(cond_out),
  .load_out(load_out), .fault_out(fault_out), .sf_used_out(sf_used_out), .amb_k_used_out(amb_k_used_out),
  .nom_used_out(nom_used_out));
`default_nettype wire

//--- verification/tol_io_partner.sv
`timescale 1ns/100ps
`default_nettype none
// binary matrix stand-in: paces program cycles and feeds blocking
module tol_io_partner #(
  parameter int GAP = 8 // clocks per program cycle
) (
  input wire logic clock_in, // clock
  input wire logic srst_in, // sync reset
  input wire logic block_req_in, // bench asks for blocking
  output logic tick_out, // cycle start pulse
  output logic block_out // blocking toward stage
);
  int cnt_r; // pacing counter
  // one-clock pulse every GAP clocks
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cnt_r <= 0;
      tick_out <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == GAP - 1) ? 0 : cnt_r + 1;
      tick_out <= (cnt_r == GAP - 1);
    end
  end
  // blocking moves on a cycle start, so the stage first sees it at the next cycle start
  always_ff @(posedge clock_in) begin
    if (srst_in) block_out <= 1'b0;
    else if (tick_out) block_out <= block_req_in;
  end
endmodule
`default_nettype wire

//--- verification/tol_stage_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tol_stage_test import tol_pkg::*; ;
  logic clock_in = 1'b0, srst_in = 1'b1, block_req = 1'b0, wr_in = 1'b0, rd_in = 1'b0; // drives
  logic [7:0] addr_in = 8'h00; // address
  logic [31:0] wdata_in = 32'h0, rv, seed = 32'h000169e8; // data, read value, xorshift state
  logic [TOL_CAP_W-1:0] cap_in = 16'h0, current_in = 16'h0, cv; // capacity and current
  wire logic cycle_tick_in, block_in; // from partner
  logic [31:0] rdata_out; // read data
  tol_outs_t outs_out; // outputs
  logic start_out, blocked_out; // indications
  tol_cond_t cond_out; // condition
  tol_load_t load_out; // load class
  tol_fault_t fault_out; // faults
  logic [TOL_FAC_W-1:0] sf_used_out, amb_k_used_out, nom_used_out; // factors used
  int num_errors = 0, checks = 0, cnt; // counters
  logic [10:0] lvl [4] = '{11'h190, 11'h190, 11'h320, 11'h3e8}; // levels in force
  logic [31:0] rst_val [12] = '{0, 32'h190, 32'h190, 32'h320, 32'h3e8, 0, 0, 32'h64, 32'h64, 32'h64, 32'h64, 0};
  logic [7:0] f_addr [6] = '{8'h1c, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h20}; // bad settings
  logic [31:0] f_val [6] = '{32'h0, 32'h1f5, 32'h0, 32'h258, 32'h0, 32'h32};
  logic [3:0] f_exp [6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h8};
  always #2.5 clock_in = ~clock_in;
  tol_io_partner tol_io_partner_inst (.clock_in(clock_in), .srst_in(srst_in), .block_req_in(block_req),
    .tick_out(cycle_tick_in), .block_out(block_in));
  tol_stage #(.STEP_CYCLES(4)) tol_stage_inst (.clock_in(clock_in), .srst_in(srst_in), .cycle_tick_in(cycle_tick_in),
    .block_in(block_in), .cap_in(cap_in), .current_in(current_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .outs_out(outs_out), .start_out(start_out),
    .blocked_out(blocked_out), .cond_out(cond_out), .load_out(load_out), .fault_out(fault_out),
    .sf_used_out(sf_used_out), .amb_k_used_out(amb_k_used_out), .nom_used_out(nom_used_out));
  // xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // outputs expected for a capacity under the levels in force
  function automatic tol_outs_t exp_outs(logic [15:0] c);
    return {c >= lvl[3], c >= lvl[2], c >= lvl[1], c >= lvl[0]};
  endfunction
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_in) begin addr_in <= a; wdata_in <= d; wr_in <= 1'b1; end
    @(posedge clock_in) wr_in <= 1'b0;
  endtask
  // one-cycle register read, data taken in the next cycle
  task automatic rd(logic [7:0] a);
    @(posedge clock_in) begin addr_in <= a; rd_in <= 1'b1; end
    @(posedge clock_in) rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask
  // wait for n cycle starts, bounded
  task automatic wt(int n);
    repeat (n) begin
      cnt = 0;
      do begin @(posedge clock_in); cnt++; end while (cycle_tick_in !== 1'b1 && cnt < 100);
      if (cnt >= 100) begin num_errors++; complete_run(); end
    end
    #1;
  endtask
  // write the four levels in force
  task automatic setlv();
    for (int j = 0; j < 4; j++) wr(8'h04 + 8'(4 * j), 32'(lvl[j]));
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    srst_in <= 1'b0;
    wr(TOL_ADDR_STATUS, 32'hffffffff);
    wr(8'h2c, 32'h12345678);
    for (int i = 0; i < 12; i++) begin
      rd(8'(4 * i));
      `CHK(rv, rst_val[i])
    end
    @(posedge clock_in) cap_in <= 16'h04b0;
    for (int e = 0; e < 16; e++) begin
      wr(TOL_ADDR_CTRL, 32'(e));
      wt(2);
      `CHK(outs_out, tol_outs_t'(e))
    end
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 4; j++) lvl[j] = 11'(xs() % 1501);
      setlv();
      cv = 16'(xs() % 1700);
      if (i == 0) cv = 16'(lvl[3]);
      if (i == 1) cv = 16'(lvl[0]) - 16'h1;
      @(posedge clock_in) cap_in <= cv;
      wt(2);
      `CHK(outs_out, exp_outs(cv))
      rd(TOL_ADDR_STATUS);
      `CHK(rv[3:0], exp_outs(cv))
    end
    lvl = '{11'h064, 11'h0c8, 11'h12c, 11'h1f4};
    setlv();
    @(posedge clock_in) cap_in <= 16'h0;
    wt(2);
    `CHK(cond_out, TOL_COND_NORMAL)
    for (int k = 1; k < 4; k++) begin
      @(posedge clock_in) cap_in <= 16'(100 * k + 50);
      wt(2);
      `CHK(cond_out, tol_cond_t'(3'(k)))
    end
    wr(TOL_ADDR_TRIP_DELAY, 32'h5);
    @(posedge clock_in) cap_in <= 16'h0258;
    wt(1);
    `CHK(start_out, 1'b1)
    cnt = 0;
    while (outs_out.trip !== 1'b1 && cnt < 60) begin @(posedge clock_in); #1 cnt++; end
    `CHK(cnt >= 20 && cnt <= 28, 1'b1)
    `CHK(cond_out, TOL_COND_TRIP)
    @(posedge clock_in) cap_in <= 16'h0;
    wt(2);
    @(posedge clock_in) cap_in <= 16'h0258;
    wt(2);
    @(posedge clock_in) cap_in <= 16'h0;
    wt(1);
    @(posedge clock_in) cap_in <= 16'h0258;
    wt(3);
    `CHK(outs_out.trip, 1'b0)
    wr(TOL_ADDR_TRIP_DELAY, 32'h0);
    block_req <= 1'b1;
    cap_in <= 16'h0;
    wt(2);
    @(posedge clock_in) cap_in <= 16'h0258;
    wt(2);
    `CHK({blocked_out, start_out, outs_out}, 6'h20)
    `CHK(cond_out, TOL_COND_BLOCKED)
    @(posedge clock_in) block_req <= 1'b0;
    wt(3);
    `CHK({start_out, outs_out}, 5'h1f)
    @(posedge clock_in) block_req <= 1'b1;
    wt(2);
    `CHK({start_out, outs_out}, 5'h00)
    @(posedge clock_in) block_req <= 1'b0;
    @(posedge clock_in) current_in <= 16'h0005;
    wt(1);
    `CHK(load_out, TOL_LOAD_LIGHT)
    @(posedge clock_in) current_in <= 16'h09c4;
    wt(1);
    `CHK(load_out, TOL_LOAD_HIGH)
    @(posedge clock_in) current_in <= 16'h04b0;
    wt(1);
    `CHK(load_out, TOL_LOAD_OVER)
    @(posedge clock_in) current_in <= 16'h0320;
    wt(1);
    `CHK(load_out, TOL_LOAD_NORMAL)
    for (int i = 0; i < 6; i++) begin
      wr(f_addr[i], f_val[i]);
      repeat (3) @(posedge clock_in);
      `CHK(fault_out, f_exp[i])
      wr(f_addr[i], 32'h64);
      repeat (3) @(posedge clock_in);
      `CHK(fault_out, 4'h0)
    end
    wr(TOL_ADDR_SERVICE_FACTOR, 32'h0fa);
    repeat (3) @(posedge clock_in);
    `CHK(sf_used_out, 10'h0fa)
    wr(TOL_ADDR_AMB_K_MAX, 32'h96);
    wr(TOL_ADDR_NOM_SCALE, 32'h1f6);
    repeat (3) @(posedge clock_in);
    `CHK(amb_k_used_out, 10'h096)
    `CHK(nom_used_out, TOL_FAC_ONE)
    complete_run();
  end
endmodule
`default_nettype wire
